// ---- logic/sfem_pkg.sv ----
// constants for the sf/e&m signaling control block
// Behaviour
// - tone on while lead idle, off busy
// - dialing sends tone only during pulse breaks
// - augmented tone level 400 ms after hangup
// - tone state follows lead after 18 ms
// - ignore lead breaks/makes shorter than delay
// - tone-on break at least 50 ms
// - tone-off make at least 25 ms
// - cut speech path 18 ms before tone
// - restore speech path 125 ms after off-hook
// - guard falls after 225 ms, rises 50 ms
// - insert notch filter 13 ms after tone
// - short tones keep notch 225 ms total
// - long tones keep notch tone plus 50
// - repeated dial breaks corrected to 58 percent
// - sense M on a-side, E on b-side
// - loopback by tone, external lead, or switch
// - tone loopback ends by tone or timeout
// - loopback isolates ports, routes rx to tx
// - loopback tone accepted after 2.5 s, on removal
// - exit tone recognised after 1.2 s, immediate
// - tone loopback timeout 4 or 20 minutes
package sfem_pkg;
  // clock rate and the millisecond timebase
  localparam int unsigned CLK_HZ = 32'h0BEBC200;
  localparam int unsigned MS_PER_S = 32'h000003E8;
  localparam int unsigned MS_PER_MIN = 32'h0000EA60;
  // signaling intervals in milliseconds, loopback timeouts in minutes
  localparam logic [11:0] LEAD_DLY_MS = 12'h012;
  localparam logic [11:0] BREAK_MIN_MS = 12'h032;
  localparam logic [11:0] MAKE_MIN_MS = 12'h019;
  localparam logic [11:0] AUG_MS = 12'h190;
  localparam logic [11:0] CUT_REM_MS = 12'h07D;
  localparam logic [11:0] GUARD_HL_MS = 12'h0E1;
  localparam logic [11:0] GUARD_LH_MS = 12'h032;
  localparam logic [11:0] NOTCH_INS_MS = 12'h00D;
  localparam logic [11:0] SHORT_TONE_MS = 12'h0AF;
  localparam logic [11:0] NOTCH_SHORT_MS = 12'h0E1;
  localparam logic [11:0] NOTCH_TAIL_MS = 12'h032;
  localparam logic [11:0] PULSE_PRD_MAX_MS = 12'h096;
  localparam logic [11:0] LOOP_ACT_MS = 12'h9C4;
  localparam logic [11:0] LOOP_DEACT_MS = 12'h4B0;
  localparam int unsigned TO_SHORT_MIN = 32'h00000004;
  localparam int unsigned TO_LONG_MIN = 32'h00000014;
  // dial pulse output break ratio
  localparam logic [18:0] OUT_BREAK_PCT = 19'h0003A;
  localparam logic [18:0] PCT_BASE = 19'h00064;
  // register map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam int CTRL_BSIDE = 0;
  localparam int CTRL_TOLONG = 1;
  localparam int CTRL_MANSW = 2;
  localparam int CTRL_GAIN_LSB = 8;
  localparam logic [5:0] GAIN_RST = 6'h00;
  // loopback controller states
  typedef enum logic [2:0] {
    LOOP_IDLE = 3'h1,
    LOOP_TONE = 3'h2,
    LOOP_DROP = 3'h4
  } sfem_loop_t;
endpackage

// ---- logic/sfem_ctrl.sv ----
// sf/e&m signaling control with loopback controller and apb registers
//
// The implementer's own choices: the address map and the APB interface to the registers.
module sfem_ctrl #(
  parameter int unsigned TICK_CYC = sfem_pkg::CLK_HZ / sfem_pkg::MS_PER_S,
  parameter int unsigned TO_SHORT_MS =
    sfem_pkg::TO_SHORT_MIN * sfem_pkg::MS_PER_MIN,
  parameter int unsigned TO_LONG_MS =
    sfem_pkg::TO_LONG_MIN * sfem_pkg::MS_PER_MIN
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lead and detector pins, busy or present is high except ext_loopback_lead_n, which is low
  input wire logic m_lead_in,
  input wire logic e_lead_in,
  input wire logic sf_tone_in,
  input wire logic guard_in,
  input wire logic loop_tone_in,
  input wire logic ext_loopback_lead_n,
  // signaling outputs
  output logic tone_key,
  output logic tone_aug,
  output logic tx_path_cut,
  output logic tone_notch_filter,
  output logic guard_state,
  output logic e_lead_out,
  output logic m_lead_out,
  // loopback outputs
  output logic loopback_relay,
  output logic rx_to_tx_route,
  output logic [5:0] loop_path_gain_select
);

  // saturating millisecond counter step
  function automatic logic [11:0] sat_inc(input logic [11:0] v);
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  // output break as fixed share of the pulse period
  function automatic logic [11:0] pct_out(input logic [11:0] v);
    logic [18:0] p;
    p = 19'(v) * sfem_pkg::OUT_BREAK_PCT;
    return 12'(p / sfem_pkg::PCT_BASE);
  endfunction

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and timebase

  logic [5:0] sync1;
  logic [5:0] sync2;
  logic m_s, e_s, sf_s, guard_s, loop_s, ext_s;
  assign {m_s, e_s, sf_s, guard_s, loop_s, ext_s} = sync2;

  // two stages on every pin; only sync2 is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {m_lead_in, e_lead_in, sf_tone_in, guard_in, loop_tone_in,
                ~ext_loopback_lead_n};
      sync2 <= sync1;
    end
  end

  logic [17:0] tb_cnt;
  logic tick;

  // one millisecond tick drives every interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt <= 18'h00000;
      tick <= 1'b0;
    end else if (tb_cnt == 18'(TICK_CYC - 1)) begin
      tb_cnt <= 18'h00000;
      tick <= 1'b1;
    end else begin
      tb_cnt <= tb_cnt + 18'h00001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic b_side, to_long, man_sw;
  logic [1:0] sel_stat;
  logic setup;
  logic [31:0] status;
  sfem_pkg::sfem_loop_t loop_st;
  logic lead_busy;
  assign setup = psel && !penable;

  // control fields; writes land at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_side <= 1'b0;
      to_long <= 1'b0;
      man_sw <= 1'b0;
      loop_path_gain_select <= sfem_pkg::GAIN_RST;
    end else if (psel && penable && pready && pwrite &&
                 paddr == sfem_pkg::CTRL_OFF) begin
      if (pstrb[0]) begin
        b_side <= pwdata[sfem_pkg::CTRL_BSIDE];
        to_long <= pwdata[sfem_pkg::CTRL_TOLONG];
        man_sw <= pwdata[sfem_pkg::CTRL_MANSW];
      end
      if (pstrb[1]) begin
        loop_path_gain_select <= pwdata[sfem_pkg::CTRL_GAIN_LSB +: 6];
      end
    end
  end

  assign status = {20'h00000, loop_st == sfem_pkg::LOOP_TONE, loopback_relay,
                   ext_s, guard_state, tone_notch_filter, m_lead_out,
                   e_lead_out, tx_path_cut, tone_aug, tone_key, lead_busy,
                   sf_s};
  assign sel_stat = {paddr == sfem_pkg::STAT_OFF,
                     paddr == sfem_pkg::CTRL_OFF};

  // no wait state: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && sel_stat == 2'h0;
      if (setup && !pwrite) begin
        unique case (sel_stat)
          2'h1: prdata <= {18'h00000, loop_path_gain_select, 5'h00, man_sw,
                           to_long, b_side};
          2'h2: prdata <= status;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lead to tone

  logic lead_raw, lead_d;
  logic [11:0] deb_cnt, hold_cnt, aug_cnt, cut_cnt;
  assign lead_raw = b_side ? e_s : m_s;

  // debounce: a change must persist for the lead delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_busy <= 1'b0;
      lead_d <= 1'b0;
      deb_cnt <= 12'h000;
    end else begin
      lead_d <= lead_busy;
      if (lead_raw == lead_busy) begin
        deb_cnt <= 12'h000;
      end else if (tick) begin
        if (deb_cnt == sfem_pkg::LEAD_DLY_MS - 12'h001) begin
          lead_busy <= lead_raw;
          deb_cnt <= 12'h000;
        end else begin
          deb_cnt <= deb_cnt + 12'h001;
        end
      end
    end
  end

  logic [1:0] owed;
  logic lead_edge, tone_go;
  assign lead_edge = lead_d != lead_busy;
  assign tone_go = owed != 2'h0 && hold_cnt >= (tone_key ?
                   sfem_pkg::BREAK_MIN_MS : sfem_pkg::MAKE_MIN_MS);

  // each accepted lead change owes one tone change; a short pulse is
  // stretched to the least break and make rather than lost mid-digit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_key <= 1'b1;
      hold_cnt <= 12'h000;
    end else if (tone_go) begin
      tone_key <= !tone_key;
      hold_cnt <= 12'h000;
    end else if (tick) begin
      hold_cnt <= sat_inc(hold_cnt);
    end
  end

  // owed changes; a third pending one cancels a pair to keep parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owed <= 2'h0;
    end else if (lead_edge && !tone_go) begin
      owed <= (owed == 2'h2) ? 2'h1 : owed + 2'h1;
    end else if (!lead_edge && tone_go) begin
      owed <= owed - 2'h1;
    end
  end

  // augmented level after each busy to idle change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_aug <= 1'b0;
      aug_cnt <= 12'h000;
    end else if (lead_d && !lead_busy) begin
      tone_aug <= 1'b1;
      aug_cnt <= 12'h000;
    end else if (tick && tone_aug) begin
      if (aug_cnt == sfem_pkg::AUG_MS - 12'h001) begin
        tone_aug <= 1'b0;
      end
      aug_cnt <= aug_cnt + 12'h001;
    end
  end

  // cut opens on raw idle, a full lead delay ahead of tone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_path_cut <= 1'b1;
      cut_cnt <= 12'h000;
    end else if (!lead_raw || !lead_busy) begin
      tx_path_cut <= 1'b1;
      cut_cnt <= 12'h000;
    end else if (tick && tx_path_cut) begin
      if (cut_cnt == sfem_pkg::CUT_REM_MS - 12'h001) begin
        tx_path_cut <= 1'b0;
      end
      cut_cnt <= cut_cnt + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive side

  logic [11:0] g_cnt, sf_cnt, nh_cnt, bt_cnt, last_prd, target;
  logic sf_d, out_break;

  // guard filter with asymmetric timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_state <= 1'b0;
      g_cnt <= 12'h000;
    end else if (guard_s == guard_state) begin
      g_cnt <= 12'h000;
    end else if (tick) begin
      if (g_cnt == (guard_state ? sfem_pkg::GUARD_HL_MS :
                    sfem_pkg::GUARD_LH_MS) - 12'h001) begin
        guard_state <= guard_s;
        g_cnt <= 12'h000;
      end else begin
        g_cnt <= g_cnt + 12'h001;
      end
    end
  end

  // notch timing; hold after tone end depends on tone length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sf_d <= 1'b0;
      sf_cnt <= 12'h000;
      nh_cnt <= 12'h000;
      tone_notch_filter <= 1'b0;
    end else begin
      sf_d <= sf_s;
      // tone-end cycle bridges the gap before the hold count loads
      tone_notch_filter <= (sf_s && sf_cnt >= sfem_pkg::NOTCH_INS_MS) ||
                           (sf_d && !sf_s) || nh_cnt != 12'h000;
      if (sf_d && !sf_s) begin
        sf_cnt <= 12'h000;
        nh_cnt <= (sf_cnt < sfem_pkg::SHORT_TONE_MS) ?
                  sfem_pkg::NOTCH_SHORT_MS - sf_cnt :
                  sfem_pkg::NOTCH_TAIL_MS;
      end else if (tick) begin
        if (sf_s) begin
          sf_cnt <= sat_inc(sf_cnt);
        end
        if (nh_cnt != 12'h000) begin
          nh_cnt <= nh_cnt - 12'h001;
        end
      end
    end
  end

  // break length from the previous pulse period; long gaps pass as is
  assign target = (last_prd <= sfem_pkg::PULSE_PRD_MAX_MS) ?
                  pct_out(last_prd) : 12'hFFF;
  assign out_break = sf_s ? (bt_cnt < target || bt_cnt >= last_prd) :
                     (bt_cnt < target && target != 12'hFFF);

  // pulse correction and output lead drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bt_cnt <= 12'hFFF;
      last_prd <= 12'hFFF;
      e_lead_out <= 1'b0;
      m_lead_out <= 1'b0;
    end else begin
      if (sf_s && !sf_d) begin
        last_prd <= bt_cnt;
        bt_cnt <= 12'h000;
      end else if (tick) begin
        bt_cnt <= sat_inc(bt_cnt);
      end
      e_lead_out <= !b_side && !out_break;
      m_lead_out <= b_side && !out_break;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loopback controller

  logic loop_d;
  logic [11:0] loop_cnt;
  logic [20:0] to_cnt, to_lim;
  assign to_lim = to_long ? 21'(TO_LONG_MS - 1) : 21'(TO_SHORT_MS - 1);

  // tone states; lead and switch causes act directly on the relay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_st <= sfem_pkg::LOOP_IDLE;
      loop_d <= 1'b0;
      loop_cnt <= 12'h000;
      to_cnt <= 21'h000000;
    end else begin
      loop_d <= loop_s;
      if (!loop_s) begin
        loop_cnt <= 12'h000;
      end else if (tick) begin
        loop_cnt <= sat_inc(loop_cnt);
      end
      unique case (loop_st)
        sfem_pkg::LOOP_IDLE: begin
          to_cnt <= 21'h000000;
          if (loop_d && !loop_s && loop_cnt >= sfem_pkg::LOOP_ACT_MS) begin
            loop_st <= sfem_pkg::LOOP_TONE;
          end
        end
        sfem_pkg::LOOP_TONE: begin
          if (loop_s && loop_cnt >= sfem_pkg::LOOP_DEACT_MS) begin
            loop_st <= sfem_pkg::LOOP_DROP;
          end else if (tick) begin
            if (to_cnt == to_lim) begin
              loop_st <= sfem_pkg::LOOP_IDLE;
            end
            to_cnt <= to_cnt + 21'h000001;
          end
        end
        sfem_pkg::LOOP_DROP: begin
          // the exit tone must not re-arm entry when it ends
          if (!loop_s) begin
            loop_st <= sfem_pkg::LOOP_IDLE;
          end
        end
        default: loop_st <= sfem_pkg::LOOP_IDLE;
      endcase
    end
  end

  // relay isolates terminal ports and loops rx driver to tx buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loopback_relay <= 1'b0;
      rx_to_tx_route <= 1'b0;
    end else begin
      loopback_relay <= loop_st == sfem_pkg::LOOP_TONE || ext_s ||
                        man_sw;
      rx_to_tx_route <= loop_st == sfem_pkg::LOOP_TONE || ext_s ||
                        man_sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_tone_idle;
    $rose(tone_key) |-> $past(owed) != 2'h0 && $past(hold_cnt) >=
      sfem_pkg::MAKE_MIN_MS;
  endproperty
  a_tone_idle: assert property (p_tone_idle)
    else $error("tone keyed with nothing owed or make too short");

  property p_tone_busy;
    $fell(tone_key) |-> $past(owed) != 2'h0 && $past(hold_cnt) >=
      sfem_pkg::BREAK_MIN_MS;
  endproperty
  a_tone_busy: assert property (p_tone_busy)
    else $error("tone dropped with nothing owed or break too short");

  property p_tone_follow;
    owed == 2'h0 && !lead_edge |-> tone_key != lead_busy;
  endproperty
  a_tone_follow: assert property (p_tone_follow)
    else $error("tone state disagrees with settled lead");

  property p_deb;
    $changed(lead_busy) |-> $past(tick) &&
      $past(deb_cnt) == sfem_pkg::LEAD_DLY_MS - 12'h001;
  endproperty
  a_deb: assert property (p_deb)
    else $error("lead accepted before the lead delay");

  property p_aug;
    lead_d && !lead_busy |=> tone_aug && aug_cnt == 12'h000;
  endproperty
  a_aug: assert property (p_aug)
    else $error("augmented level not started after hangup");

  property p_cut;
    $rose(tone_key) |-> tx_path_cut && $past(tx_path_cut);
  endproperty
  a_cut: assert property (p_cut)
    else $error("tone started with speech path closed");

  property p_cut_rem;
    $fell(tx_path_cut) |-> lead_busy && $past(lead_raw);
  endproperty
  a_cut_rem: assert property (p_cut_rem)
    else $error("path cut removed without off-hook");

  property p_notch;
    sf_s && sf_cnt >= sfem_pkg::NOTCH_INS_MS |=> tone_notch_filter;
  endproperty
  a_notch: assert property (p_notch)
    else $error("notch not inserted during tone");

  property p_loop;
    ext_s || man_sw |-> ##1 loopback_relay && rx_to_tx_route;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback not entered on lead or switch");

endmodule

// ---- verif/sfem_far_end.sv ----
// far-end model: trunk e&m leads and sf facility detector lines
module sfem_far_end (
  // clock
  input wire logic pclk,
  // lead, tone and loopback lines toward the block
  output logic m_lead_in,
  output logic e_lead_in,
  output logic sf_tone_in,
  output logic guard_in,
  output logic loop_tone_in,
  output logic ext_loopback_lead_n
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////
  // everything idle at time zero, loopback lead left open
  initial begin
    m_lead_in = 1'b0;
    e_lead_in = 1'b0;
    sf_tone_in = 1'b0;
    guard_in = 1'b0;
    loop_tone_in = 1'b0;
    ext_loopback_lead_n = 1'b1;
  end
  // lines change just after an edge so no sampling race with the block
  task automatic set(input int sel, input logic v);
    @(posedge pclk);
    case (sel)
      0: m_lead_in <= v;
      1: e_lead_in <= v;
      2: sf_tone_in <= v;
      3: guard_in <= v;
      4: loop_tone_in <= v;
      default: ext_loopback_lead_n <= !v;
    endcase
  endtask
endmodule

// ---- verif/sf_em_signaling_control_test.sv ----
// self-checking bench for the sf/e&m signaling control block
module sf_em_signaling_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10; // cycles per ms, shortened timebase
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic m_lead_in, e_lead_in, sf_tone_in, guard_in, loop_tone_in;
  logic ext_loopback_lead_n, tone_key, tone_aug, tx_path_cut;
  logic tone_notch_filter, guard_state, e_lead_out, m_lead_out;
  logic loopback_relay, rx_to_tx_route;
  logic [5:0] gain;
  logic [8:0] obs;
  int error_cnt, tests_run, cyc, t0, t1, k;
  //////////////////////////////////////////////////////////////////////////
  // observed outputs packed so one wait task serves them all
  assign obs = {rx_to_tx_route, loopback_relay, m_lead_out, e_lead_out,
    guard_state, tone_notch_filter, tx_path_cut, tone_aug, tone_key};
  // clock and cycle count
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // long timeouts cut so tone loopback exits stay in reach
  sfem_ctrl #(.TICK_CYC(T), .TO_SHORT_MS(200), .TO_LONG_MS(2000)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .m_lead_in(m_lead_in), .e_lead_in(e_lead_in),
    .sf_tone_in(sf_tone_in), .guard_in(guard_in),
    .loop_tone_in(loop_tone_in), .ext_loopback_lead_n(ext_loopback_lead_n),
    .tone_key(tone_key), .tone_aug(tone_aug), .tx_path_cut(tx_path_cut),
    .tone_notch_filter(tone_notch_filter), .guard_state(guard_state),
    .e_lead_out(e_lead_out), .m_lead_out(m_lead_out),
    .loopback_relay(loopback_relay), .rx_to_tx_route(rx_to_tx_route),
    .loop_path_gain_select(gain));
  sfem_far_end far_u (
    .pclk(pclk), .m_lead_in(m_lead_in), .e_lead_in(e_lead_in),
    .sf_tone_in(sf_tone_in), .guard_in(guard_in),
    .loop_tone_in(loop_tone_in), .ext_loopback_lead_n(ext_loopback_lead_n));
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // interval in cycles against ms bounds, one tick of grid slack
  task automatic rng(input int n, input int lo, input int hi, string m);
    check(n >= lo * T - T && n <= hi * T + T, m);
  endtask
  task automatic ms(input int n);
    repeat (n * T) @(posedge pclk);
  endtask
  // bounded wait for an output level; expiry ends the run
  task automatic wt(input int b, input logic v, input int lim);
    for (int i = 0; i < lim * T && obs[b] !== v; i++) @(posedge pclk);
    if (obs[b] !== v) begin
      check(1'b0, "wait expired");
      final_report();
    end
  endtask
  // apb transfer held until pready is sampled high
  task automatic apb(input bit w, input logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(1'b0, "no pready");
      final_report();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    check(obs === 9'h005, "reset outputs");
    presetn <= 1'b1;
    // registers, an unmapped word and a masked byte lane
    apb(1'b0, 12'h004, 32'h0);
    check(rd[4:0] === 5'h14, "status idle");
    apb(1'b0, 12'h008, 32'h0);
    check(er === 1'b1 && rd === 32'h0, "unmapped");
    apb(1'b1, 12'h000, 32'h00002A00);
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h00003F00);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    check(rd === 32'h00002A00 && gain === 6'h2A, "gain");
    // glitch shorter than the lead delay, then a real seizure
    far_u.set(0, 1'b1);
    ms(10);
    far_u.set(0, 1'b0);
    ms(30);
    check(obs[0] === 1'b1, "glitch keyed");
    far_u.set(0, 1'b1);
    t0 = cyc;
    wt(0, 1'b0, 40);
    rng(cyc - t0, 13, 23, "seize delay");
    wt(2, 1'b0, 200);
    rng(cyc - t0, 75, 175, "cut removal");
    // hang-up: path cut leads the tone, then augmented level
    ms(60);
    far_u.set(0, 1'b0);
    t0 = cyc;
    wt(2, 1'b1, 10);
    t1 = cyc;
    wt(0, 1'b1, 40);
    rng(cyc - t1, 13, 23, "cut lead");
    rng(cyc - t0, 13, 23, "release delay");
    wt(1, 1'b1, 2);
    wt(1, 1'b0, 600);
    rng(cyc - t0, 318, 518, "aug level");
    // dial pulse: short break and make stretched to minimums
    far_u.set(0, 1'b1);
    wt(0, 1'b0, 40);
    ms(60);
    far_u.set(0, 1'b0);
    wt(0, 1'b1, 40);
    t0 = cyc;
    far_u.set(0, 1'b1);
    ms(21);
    far_u.set(0, 1'b0);
    wt(0, 1'b0, 80);
    check(cyc - t0 >= 48 * T, "short break");
    t0 = cyc;
    wt(0, 1'b1, 80);
    check(cyc - t0 >= 23 * T, "short make");
    // received tones: notch timing and repeated lead
    far_u.set(2, 1'b1);
    t0 = cyc;
    wt(3, 1'b1, 30);
    rng(cyc - t0, 6, 20, "notch insert");
    ms(90);
    far_u.set(2, 1'b0);
    wt(3, 1'b0, 300);
    rng(cyc - t0, 175, 275, "short notch");
    ms(100);
    far_u.set(2, 1'b1);
    ms(300);
    check(obs[6:5] === 2'b00, "lead out in tone");
    far_u.set(2, 1'b0);
    t0 = cyc;
    wt(3, 1'b0, 80);
    rng(cyc - t0, 40, 60, "long notch");
    ms(100);
    check(obs[6:5] === 2'b01, "e lead busy");
    // 10 pps with 60 percent breaks, third break measured
    for (k = 0; k < 3; k++) begin
      far_u.set(2, 1'b1);
      t0 = cyc;
      if (k == 2) begin
        wt(5, 1'b0, 20);
        t1 = cyc;
        wt(5, 1'b1, 70);
        rng(cyc - t1, 54, 62, "pulse break");
      end
      repeat (60 * T - (cyc - t0)) @(posedge pclk);
      far_u.set(2, 1'b0);
      ms(39);
    end
    // guard filter both ways
    far_u.set(3, 1'b1);
    t0 = cyc;
    wt(4, 1'b1, 70);
    rng(cyc - t0, 40, 60, "guard rise");
    far_u.set(3, 1'b0);
    t0 = cyc;
    wt(4, 1'b0, 300);
    rng(cyc - t0, 165, 285, "guard fall");
    // b side senses e lead, ignores m lead
    apb(1'b1, 12'h000, 32'h00000001);
    far_u.set(0, 1'b1);
    ms(40);
    check(obs[0] === 1'b1, "b side took m");
    check(obs[6:5] === 2'b10, "m lead busy");
    far_u.set(0, 1'b0);
    far_u.set(1, 1'b1);
    t0 = cyc;
    wt(0, 1'b0, 40);
    rng(cyc - t0, 13, 23, "e lead seize");
    far_u.set(1, 1'b0);
    wt(0, 1'b1, 40);
    // external lead and manual switch loopback
    far_u.set(5, 1'b1);
    ms(1);
    check(obs[8:7] === 2'b11, "ext loopback");
    far_u.set(5, 1'b0);
    ms(1);
    check(obs[8:7] === 2'b00, "ext release");
    apb(1'b1, 12'h000, 32'h00000004);
    ms(1);
    check(obs[8:7] === 2'b11, "switch loopback");
    apb(1'b1, 12'h000, 32'h00000000);
    ms(1);
    check(obs[8:7] === 2'b00, "switch open");
    // tone loopback: entry on removal, short timeout
    far_u.set(4, 1'b1);
    ms(2600);
    check(obs[7] === 1'b0, "entered in tone");
    far_u.set(4, 1'b0);
    t0 = cyc;
    wt(7, 1'b1, 5);
    wt(7, 1'b0, 250);
    rng(cyc - t0, 190, 210, "short timeout");
    // long timeout mode, left by a second tone
    apb(1'b1, 12'h000, 32'h00000002);
    far_u.set(4, 1'b1);
    ms(2600);
    far_u.set(4, 1'b0);
    wt(7, 1'b1, 5);
    far_u.set(4, 1'b1);
    t0 = cyc;
    wt(7, 1'b0, 1250);
    rng(cyc - t0, 1200, 1205, "exit tone");
    far_u.set(4, 1'b0);
    final_report();
  end
endmodule
